// [inc/sram_port_pkg.sv]
// Constants shared by the synchronous no-turnaround SRAM port model
package sram_port_pkg;
    // ****************************************
    // Geometry
    // ****************************************
    localparam int BYTE_BITS = 9;
    localparam int BYTE_COUNT = 4;
    localparam int WORD_BITS = BYTE_BITS * BYTE_COUNT;
    localparam int DATA_BITS = 32;
    localparam int PARITY_BITS = 4;
    localparam int BURST_BITS = 2;
    // ****************************************
    // Reset values, cycle counts and FIFO depth
    // ****************************************
    localparam logic [1:0] BURST_RESET = 2'h0;
    localparam int DATA_DELAY_CYCLES = 1;
    localparam int FIFO_DEPTH = 8;
endpackage

// [rtl/sram_port.sv]
// Synchronous no-turnaround SRAM port with flow-through reads and a write data FIFO
`timescale 1ns/100ps
// ****************************************
// Behaviour
// ****************************************
// Behaviour
// - Word is four 9-bit bytes, each with its own active-low write enable.
// - Byte enables are ignored when read_not_write is sampled high.
// - Selected bytes are written with data taken one cycle after the command.
// - Load with any chip select false starts a deselect cycle.
// - Data bus goes high impedance one cycle after deselect starts.
// - Active-high select equals the active-low ones except polarity; all must be true.
// - Synchronous inputs sampled on rising clock; output enable is the exception.
// - Write data and parity captured into an input register on the rising edge.
// - Read data flows from array to data lines without output register.
// - burst_order_select high picks interleaved order, low picks linear order.
// - drive_enable_n high floats the data lines asynchronously; low lets reads drive.
// - sleep_request high gates the clock internally into lowest power.
// - Array contents survive sleep unchanged.
// - sleep_request is weakly pulled low inside the device.
// - Load selected takes address and control; load deselected ends any burst.
// - advance_or_load high ignores address and advances the burst counter.
// - read_not_write in a load picks read or write; data moves one cycle later.
// - clock_gate_n high makes the edge count as though it never happened.

// ****************************************
// Write data FIFO
// ****************************************
module write_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign in_ready_out = (count_r != (AW+1)'(DEPTH));
    assign out_valid_out = (count_r != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_r[rd_ptr_r];

    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ****************************************
// SRAM port top
// ****************************************
module sram_port #(
    parameter int ADDR_BITS = 6,
    parameter int FIFO_WORDS = sram_port_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [ADDR_BITS-1:0] address_in,
    input wire logic advance_or_load_in,
    input wire logic read_not_write_in,
    input wire logic clock_gate_n_in,
    input wire logic [sram_port_pkg::BYTE_COUNT-1:0] byte_write_n_in,
    input wire logic chip_select_low_a_in,
    input wire logic chip_select_low_b_in,
    input wire logic chip_select_high_in,
    input wire logic burst_order_select_in,
    input wire logic drive_enable_n_in,
    input wire logic sleep_request_in,
    input wire logic [sram_port_pkg::DATA_BITS-1:0] data_lines_in,
    input wire logic [sram_port_pkg::PARITY_BITS-1:0] parity_lines_in,
    output logic [sram_port_pkg::DATA_BITS-1:0] data_lines_out,
    output logic [sram_port_pkg::PARITY_BITS-1:0] parity_lines_out,
    output logic data_lines_oe_n_out,
    output logic write_overflow_out
);
    localparam int WB = sram_port_pkg::WORD_BITS;
    localparam int BB = sram_port_pkg::BYTE_BITS;
    localparam int NB = sram_port_pkg::BYTE_COUNT;
    localparam int DB = sram_port_pkg::DATA_BITS;
    localparam int FW = ADDR_BITS + NB + WB;

    logic [WB-1:0] array_r [2**ADDR_BITS];
    logic [ADDR_BITS-1:0] base_addr_r;
    logic [1:0] start_r;
    logic [1:0] step_r;
    logic rd_burst_r;
    logic sel_burst_r;
    logic xfer_valid_r;
    logic xfer_read_r;
    logic [ADDR_BITS-1:0] xfer_addr_r;
    logic [NB-1:0] xfer_bw_n_r;
    logic [WB-1:0] wr_word_r;
    logic [ADDR_BITS-1:0] wr_addr_r;
    logic [NB-1:0] wr_bw_n_r;
    logic wr_valid_r;
    logic [WB-1:0] read_word;
    logic [ADDR_BITS-1:0] rd_addr;
    logic [1:0] offset;
    logic [ADDR_BITS-1:0] burst_addr;
    logic edge_live;
    logic sleep_eff;
    logic selected;
    logic load;
    logic advance;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [FW-1:0] fifo_out_data;
    logic [FW-1:0] fifo_in_data;
    logic [WB-1:0] merged;
    logic [WB-1:0] cur_word;

    // ****************************************
    // Cycle qualification
    // ****************************************
    assign sleep_eff = (sleep_request_in === 1'b1);
    assign edge_live = !clock_gate_n_in && !sleep_eff;
    assign selected = !chip_select_low_a_in && !chip_select_low_b_in
        && chip_select_high_in;
    assign load = edge_live && !advance_or_load_in && selected;
    assign advance = edge_live && advance_or_load_in && sel_burst_r;

    // Interleaved is xor, linear is add with wrap
    always_comb begin
        if (burst_order_select_in) begin
            offset = start_r ^ step_r;
        end else begin
            offset = start_r + step_r;
        end
    end
    assign burst_addr = {base_addr_r[ADDR_BITS-1:2], offset};

    // ****************************************
    // Address, control and burst counter
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            base_addr_r <= '0;
            start_r <= sram_port_pkg::BURST_RESET;
            step_r <= sram_port_pkg::BURST_RESET;
            rd_burst_r <= 1'b0;
            sel_burst_r <= 1'b0;
        end else if (edge_live) begin
            if (!advance_or_load_in) begin
                if (selected) begin
                    base_addr_r <= address_in;
                    start_r <= address_in[1:0];
                    // First advance moves on to the next word of the burst
                    step_r <= 2'h1;
                    rd_burst_r <= read_not_write_in;
                end
                sel_burst_r <= selected;
            end else if (sel_burst_r) begin
                step_r <= step_r + 2'h1;
            end
        end
    end

    // ****************************************
    // Transfer stage, one cycle after command
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            xfer_valid_r <= 1'b0;
            xfer_read_r <= 1'b0;
            xfer_addr_r <= '0;
            xfer_bw_n_r <= '1;
        end else if (edge_live) begin
            xfer_valid_r <= load || advance;
            xfer_read_r <= load ? read_not_write_in : rd_burst_r;
            xfer_addr_r <= load ? address_in : burst_addr;
            xfer_bw_n_r <= (load ? read_not_write_in : rd_burst_r) ? '1
                : byte_write_n_in;
        end
    end

    // Write data captured into input register then queued
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            wr_valid_r <= 1'b0;
            wr_word_r <= '0;
            wr_addr_r <= '0;
            wr_bw_n_r <= '1;
        end else begin
            if (edge_live) begin
                wr_valid_r <= xfer_valid_r && !xfer_read_r;
                wr_word_r <= {parity_lines_in[3], data_lines_in[31:24],
                    parity_lines_in[2], data_lines_in[23:16],
                    parity_lines_in[1], data_lines_in[15:8],
                    parity_lines_in[0], data_lines_in[7:0]};
                wr_addr_r <= xfer_addr_r;
                wr_bw_n_r <= xfer_bw_n_r;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            write_overflow_out <= 1'b0;
        end else if (wr_valid_r && edge_live && !fifo_in_ready) begin
            write_overflow_out <= 1'b1;
        end
    end

    assign fifo_in_data = {wr_addr_r, wr_bw_n_r, wr_word_r};

    write_fifo #(.WIDTH(FW), .DEPTH(FIFO_WORDS)) u_fifo (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .in_valid_in(wr_valid_r && edge_live),
        .in_ready_out(fifo_in_ready),
        .in_data_in(fifo_in_data),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(!sleep_eff),
        .out_data_out(fifo_out_data)
    );

    // ****************************************
    // Array
    // ****************************************
    assign cur_word = array_r[fifo_out_data[FW-1 -: ADDR_BITS]];
    always_comb begin
        merged = cur_word;
        for (int i = 0; i < NB; i++) begin
            if (!fifo_out_data[WB + i]) begin
                merged[i*BB +: BB] = fifo_out_data[i*BB +: BB];
            end
        end
    end

    // Sleep holds writes back, contents are untouched
    always_ff @(posedge sys_clk_in) begin
        if (fifo_out_valid && !sleep_eff) begin
            array_r[fifo_out_data[FW-1 -: ADDR_BITS]] <= merged;
        end
    end

    // Read uses the queued-write view so a fresh write reads back
    always_comb begin
        rd_addr = xfer_addr_r;
        read_word = array_r[rd_addr];
        if (fifo_out_valid && fifo_out_data[FW-1 -: ADDR_BITS] == rd_addr) begin
            read_word = merged;
        end
        if (wr_valid_r && wr_addr_r == rd_addr) begin
            for (int i = 0; i < NB; i++) begin
                if (!wr_bw_n_r[i]) begin
                    read_word[i*BB +: BB] = wr_word_r[i*BB +: BB];
                end
            end
        end
    end

    // ****************************************
    // Flow-through output drive
    // ****************************************
    always_comb begin
        for (int i = 0; i < NB; i++) begin
            data_lines_out[i*8 +: 8] = read_word[i*BB +: 8];
            parity_lines_out[i] = read_word[i*BB + 8];
        end
    end
    assign data_lines_oe_n_out = !(xfer_valid_r && xfer_read_r
        && !drive_enable_n_in);
endmodule

// [sim/ctrl_model.sv]
// Memory controller model driving address, control and write data
`timescale 1ns/100ps
module ctrl_model (
    input wire logic sys_clk_in,
    output logic [7:0] ctl_out,
    output logic [3:0] bw_out,
    output logic [5:0] addr_out,
    output logic [35:0] wd_out
);
    initial begin
        ctl_out = 8'h00;
        bw_out = 4'hf;
        addr_out = 6'h00;
        wd_out = 36'h0;
    end
    // Control bits: adv, rnw, gate, sleep, drive enable, selects a, b, high
    task automatic cyc(input logic [7:0] c, input logic [5:0] a = 6'h3f,
        input logic [3:0] bw = 4'h0, input logic wen = 1'b0, input logic [35:0] wd = 36'h0);
        @(posedge sys_clk_in);
        ctl_out <= c;
        addr_out <= a;
        bw_out <= bw;
        wd_out <= wen ? wd : ~wd_out;
    endtask
endmodule

// [sim/sram_port_checker.sv]
// Port-level assertions for the SRAM port
`timescale 1ns/100ps
module sram_port_checker (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic advance_or_load_in,
    input wire logic read_not_write_in,
    input wire logic clock_gate_n_in,
    input wire logic chip_select_low_a_in,
    input wire logic chip_select_low_b_in,
    input wire logic chip_select_high_in,
    input wire logic drive_enable_n_in,
    input wire logic sleep_request_in,
    input wire logic [sram_port_pkg::DATA_BITS-1:0] data_lines_out,
    input wire logic data_lines_oe_n_out
);
    wire go = !clock_gate_n_in && !sleep_request_in;
    wire sel = !chip_select_low_a_in && !chip_select_low_b_in && chip_select_high_in;
    wire ld = go && !advance_or_load_in;
    wire rd = ld && sel && read_not_write_in;
    wire wr = ld && sel && !read_not_write_in;
    wire adv = go && advance_or_load_in;
    wire den = drive_enable_n_in;
    wire oe_n = data_lines_oe_n_out;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    desel_float_a: assert property (ld && !sel |=> oe_n)
        else $error("bus driven after deselect");
    write_float_a: assert property (wr |=> oe_n)
        else $error("bus driven in write data cycle");
    read_drive_a: assert property (rd ##1 !den |-> !oe_n)
        else $error("read data not driven");
    burst_read_a: assert property (rd ##1 adv ##1 !den |-> !oe_n)
        else $error("burst read not driven");
    burst_write_a: assert property (wr ##1 adv |=> oe_n)
        else $error("burst write drives bus");
    den_float_a: assert property (den |-> oe_n)
        else $error("bus driven while disabled");
    gate_hold_a: assert property (clock_gate_n_in ##1 $stable(den) |->
        $stable(oe_n) && $stable(data_lines_out)) else $error("outputs moved on gated edge");
    sleep_hold_a: assert property (sleep_request_in ##1 $stable(den) |->
        $stable(oe_n) && $stable(data_lines_out)) else $error("outputs moved in sleep");
endmodule

bind sram_port sram_port_checker i_sram_port_checker (.sys_clk_in, .rst_in,
    .advance_or_load_in, .read_not_write_in, .clock_gate_n_in, .chip_select_low_a_in,
    .chip_select_low_b_in, .chip_select_high_in, .drive_enable_n_in, .sleep_request_in,
    .data_lines_out, .data_lines_oe_n_out);

// [sim/tb_top.sv]
// Self-checking testbench for the SRAM port
`timescale 1ns/100ps
module tb_top;
    localparam logic [7:0] LDR = 8'h41;
    localparam logic [7:0] LDW = 8'h01;
    localparam logic [7:0] ADV = 8'h81;
    localparam logic [7:0] DSL = 8'h00;
    localparam logic [35:0] BASE = 36'h912345670;
    logic sys_clk;
    logic rst;
    logic bos;
    logic [7:0] ctl;
    logic [3:0] bw;
    logic [5:0] addr;
    logic [35:0] wd;
    logic [31:0] dout;
    logic [3:0] pout;
    logic oe_n;
    logic ovf;
    wire [35:0] bus = oe_n ? wd : {pout, dout};
    int num_errors = 0;
    int tests_run = 0;
    ctrl_model i_ctrl_model (.sys_clk_in(sys_clk), .ctl_out(ctl), .bw_out(bw),
        .addr_out(addr), .wd_out(wd));
    sram_port i_sram_port (.sys_clk_in(sys_clk), .rst_in(rst), .address_in(addr),
        .advance_or_load_in(ctl[7]), .read_not_write_in(ctl[6]), .clock_gate_n_in(ctl[5]),
        .byte_write_n_in(bw), .chip_select_low_a_in(ctl[2]), .chip_select_low_b_in(ctl[1]),
        .chip_select_high_in(ctl[0]), .burst_order_select_in(bos),
        .drive_enable_n_in(ctl[3]), .sleep_request_in(ctl[4]), .data_lines_in(bus[31:0]),
        .parity_lines_in(bus[35:32]), .data_lines_out(dout), .parity_lines_out(pout),
        .data_lines_oe_n_out(oe_n), .write_overflow_out(ovf));
    task automatic chk(input logic [35:0] got, input logic [35:0] exp, input logic [35:0] m);
        tests_run++;
        if ((got & m) !== (exp & m)) begin
            num_errors++;
            $display("[FAIL] %0t word %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t flag %b", $time, got);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Back-to-back writes and reads, partial bytes, ignored enables on reads
    task automatic t_bytes;
        i_ctrl_model.cyc(LDW, 6'h04);
        i_ctrl_model.cyc(LDW, 6'h05, 4'ha, 1'b1, BASE);
        i_ctrl_model.cyc(LDR, 6'h04, 4'h0, 1'b1, ~BASE);
        i_ctrl_model.cyc(LDR, 6'h05);
        #1 chk(bus, BASE, '1);
        i_ctrl_model.cyc(8'h08, 6'h3f, 4'h0, 1'b1, 36'h0);
        #1 chk_bit(oe_n, 1'b1);
        i_ctrl_model.cyc(LDR, 6'h05);
        i_ctrl_model.cyc(DSL);
        #1 chk(bus, ~BASE, 36'h500ff00ff);
    endtask
    // Burst write, then burst reads in both orders
    task automatic t_burst;
        i_ctrl_model.cyc(LDW, 6'h08);
        for (int k = 0; k < 4; k++) begin
            i_ctrl_model.cyc(k < 3 ? ADV : DSL, 6'h3f, 4'h0, 1'b1, BASE + 36'(k));
        end
        for (int m = 0; m < 2; m++) begin
            bos <= m[0];
            i_ctrl_model.cyc(LDR, 6'h09);
            for (int j = 0; j < 4; j++) begin
                i_ctrl_model.cyc(j < 3 ? ADV : DSL);
                #1 chk(bus, BASE + 36'(m ? (1 ^ j) : ((1 + j) & 3)), '1);
            end
        end
    endtask
    // Each chip select alone deselects and ends the burst
    task automatic t_select;
        logic [7:0] v [3] = '{8'h00, 8'h05, 8'h03};
        foreach (v[i]) begin
            i_ctrl_model.cyc(LDR, 6'h04);
            i_ctrl_model.cyc(v[i]);
            #1 chk_bit(oe_n, 1'b0);
            i_ctrl_model.cyc(ADV);
            #1 chk_bit(oe_n, 1'b1);
            i_ctrl_model.cyc(DSL);
            #1 chk_bit(oe_n, 1'b1);
        end
    endtask
    // Gated and sleeping edges freeze the burst; contents survive sleep
    task automatic t_gate;
        i_ctrl_model.cyc(LDR, 6'h08);
        i_ctrl_model.cyc(8'ha1);
        #1 chk(bus, BASE, '1);
        i_ctrl_model.cyc(ADV);
        #1 chk(bus, BASE, '1);
        i_ctrl_model.cyc(8'h91);
        #1 chk(bus, BASE + 36'h1, '1);
        i_ctrl_model.cyc(DSL);
        #1 chk(bus, BASE + 36'h1, '1);
        i_ctrl_model.cyc(LDR, 6'h04);
        i_ctrl_model.cyc(DSL);
        #1 chk(bus, BASE, '1);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (2000) @(posedge sys_clk);
        num_errors++;
        wrap_up;
    end
    initial begin
        rst = 1'b1;
        bos = 1'b0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        #1 chk_bit(oe_n, 1'b1);
        chk_bit(ovf, 1'b0);
        t_bytes;
        t_burst;
        t_select;
        t_gate;
        chk_bit(ovf, 1'b0);
        wrap_up;
    end
endmodule
